// >>> rdm_pkg.sv
package rdm_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] RDM_ROM0_ADDR   = 32'h0320_0080;
   localparam logic [31:0] RDM_ROM1_ADDR   = 32'h0320_0084;
   localparam logic [31:0] RDM_DCTL_ADDR   = 32'h0320_00d0;
   localparam logic [31:0] RDM_FORCE_ADDR  = 32'h0320_00d4;
   localparam logic [31:0] RDM_REFP_ADDR   = 32'h0320_00d8;
   localparam logic [31:0] RDM_STAT_ADDR   = 32'h0320_00dc;

   // ------------------------------------------------------------
   // rom configuration byte fields and reset
   // ------------------------------------------------------------
   localparam int RDM_ROM_WE_BIT    = 7;
   localparam int RDM_ROM_W16_BIT   = 6;
   localparam int RDM_ROM_FULL_BIT  = 5;
   localparam int RDM_ROM_BURST_LSB = 3;
   localparam int RDM_ROM_NSEQ_LSB  = 0;
   localparam logic [7:0] RDM_ROM_RESET = 8'h40;

   // ------------------------------------------------------------
   // dram control fields and reset
   // ------------------------------------------------------------
   localparam int RDM_DCTL_PRE_BIT = 7;
   localparam int RDM_DCTL_RCD_BIT = 6;
   localparam int RDM_DCTL_EDO_BIT = 5;
   localparam logic [7:0] RDM_DCTL_RESET  = 8'h00;
   localparam logic [7:0] RDM_FORCE_RESET = 8'h00;
   localparam logic [1:0] RDM_REFP_RESET  = 2'h0;

   // ------------------------------------------------------------
   // timing counts in memory clock cycles, with the clock in MHz and the refresh limit in us
   // ------------------------------------------------------------
   localparam int RDM_NSEQ_MAX    = 7;
   localparam int RDM_BURST_MAX   = 4;
   localparam int RDM_MAX_BURST   = 255;
   localparam int RDM_RCD_BASE    = 2;
   localparam int RDM_PRE_BASE    = 3;
   localparam int RDM_CLK_MHZ     = 200;
   localparam int RDM_REF_US_MAX  = 128;
   // refresh period in cycles for the longest setting
   localparam int RDM_REF_CYC_MAX = RDM_REF_US_MAX * RDM_CLK_MHZ;
endpackage

// >>> rdm_mem_if.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module rdm_mem_if #(
   parameter int REF_CYC_MAX = rdm_pkg::RDM_REF_CYC_MAX
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic [31:0] i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [31:0] o_reg_rdata,
   input  wire logic        i_req,
   input  wire logic        i_req_wr,
   input  wire logic        i_req_seq,
   input  wire logic [28:0] i_req_addr,
   input  wire logic [3:0]  i_req_be,
   input  wire logic [31:0] i_req_wdata,
   output logic             o_req_done,
   output logic      [31:0] o_req_rdata,
   input  wire logic [15:0] i_mem_rdata,
   output logic      [31:0] o_mem_wdata,
   output logic             o_mem_wdata_oen,
   output logic             o_rom_cs_n,
   output logic             o_io_read_strobe_n,
   output logic             o_io_write_strobe_n,
   output logic      [3:0]  o_row_strobe_n,
   output logic      [3:0]  o_column_strobe_n,
   output logic      [11:0] o_dram_mux_address
);
   import rdm_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] rom_cfg_q [2];
   logic [7:0] dctl_q;
   logic [7:0] force_q;
   logic [1:0] refp_q;
   logic [15:0] mem_rdata_s1_q, mem_rdata_q;

   // map a rom speed code onto a cycle count, doubled at half speed
   function automatic logic [4:0] rom_len(input logic [7:0] cfg, input logic burst);
      logic [3:0] base;
      base = burst ? 4'(RDM_BURST_MAX + 1) - 4'(cfg[RDM_ROM_BURST_LSB +: 2])
                   : 4'(RDM_NSEQ_MAX) - 4'(cfg[RDM_ROM_NSEQ_LSB +: 3]);
      if (!burst && cfg[RDM_ROM_NSEQ_LSB +: 3] > 3'h5) base = 4'h2;
      rom_len = cfg[RDM_ROM_FULL_BIT] ? {1'b0, base} : {base, 1'b0};
   endfunction

   // register writes
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         rom_cfg_q[0] <= RDM_ROM_RESET;
         rom_cfg_q[1] <= RDM_ROM_RESET;
         dctl_q       <= RDM_DCTL_RESET;
         force_q      <= RDM_FORCE_RESET;
         refp_q       <= RDM_REFP_RESET;
      end else if (i_reg_wr) begin
         unique case (i_reg_addr)
            RDM_ROM0_ADDR:  rom_cfg_q[0] <= i_reg_wdata[7:0];
            RDM_ROM1_ADDR:  rom_cfg_q[1] <= i_reg_wdata[7:0];
            RDM_DCTL_ADDR:  dctl_q  <= {i_reg_wdata[7:5], 1'b0, i_reg_wdata[3:0]};
            RDM_FORCE_ADDR: force_q <= i_reg_wdata[7:0];
            RDM_REFP_ADDR:  refp_q  <= i_reg_wdata[1:0];
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   typedef enum {S_IDLE, S_ROM, S_RAS, S_CAS, S_TAIL, S_PRE, S_REF} rdm_state_e;
   rdm_state_e st_q;
   logic [4:0]  cnt_q;
   logic [28:0] addr_q;
   logic        wr_q, half_q, w16_q, bank_w16;
   logic [1:0]  bank_q;
   logic [3:0]  be_q;
   logic [31:0] wdata_q;
   logic [7:0]  burst_q;
   logic        open_q;
   logic [1:0]  open_bank_q;
   logic [15:0] rlo_q;
   logic        ref_pend_q;
   logic [$clog2(REF_CYC_MAX+1)-1:0] ref_cnt_q;
   logic        is_rom, rom_sel, edo;
   logic [4:0]  cas_len;

   assign is_rom   = (i_req_addr[28:25] == 4'h0);
   assign rom_sel  = i_req_addr[24];
   assign bank_w16 = dctl_q[i_req_addr[27:26]];
   assign edo      = dctl_q[RDM_DCTL_EDO_BIT];
   assign cas_len  = edo ? 5'd2 : 5'd1;

   // refresh timer: period = max >> code, four choices
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         ref_cnt_q  <= '0;
         ref_pend_q <= 1'b0;
      end else begin
         if (ref_cnt_q >= ($bits(ref_cnt_q))'((REF_CYC_MAX >> refp_q) - 1)) begin
            ref_cnt_q  <= '0;
            ref_pend_q <= 1'b1;
         end else begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
            if (st_q == S_REF) ref_pend_q <= 1'b0;
         end
      end
   end

   // input data pins pass two flops
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         mem_rdata_s1_q <= '0;
         mem_rdata_q    <= '0;
      end else begin
         mem_rdata_s1_q <= i_mem_rdata;
         mem_rdata_q    <= mem_rdata_s1_q;
      end
   end

   // main state machine
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         st_q        <= S_IDLE;
         cnt_q       <= '0;
         addr_q      <= '0;
         wr_q        <= 1'b0;
         half_q      <= 1'b0;
         w16_q       <= 1'b0;
         bank_q      <= '0;
         be_q        <= '0;
         wdata_q     <= '0;
         burst_q     <= '0;
         open_q      <= 1'b0;
         open_bank_q <= '0;
         rlo_q       <= '0;
         o_req_done  <= 1'b0;
         o_req_rdata <= '0;
      end else begin
         o_req_done <= 1'b0;
         cnt_q      <= (cnt_q != 0) ? cnt_q - 1'b1 : cnt_q;
         unique case (st_q)
            S_IDLE: begin
               if (ref_pend_q) begin
                  open_q <= 1'b0;
                  st_q   <= S_REF;
                  cnt_q  <= 5'd4;
               end else if (i_req && !o_req_done) begin
                  addr_q  <= i_req_addr;
                  wr_q    <= i_req_wr;
                  be_q    <= i_req_be;
                  wdata_q <= i_req_wdata;
                  half_q  <= 1'b0;
                  if (is_rom) begin
                     w16_q <= rom_cfg_q[rom_sel][RDM_ROM_W16_BIT];
                     if (i_req_wr && !rom_cfg_q[rom_sel][RDM_ROM_WE_BIT])
                        o_req_done <= 1'b1;                                // write blocked
                     else begin
                        st_q  <= S_ROM;
                        cnt_q <= rom_len(rom_cfg_q[rom_sel],
                                 i_req_seq && rom_cfg_q[rom_sel][RDM_ROM_BURST_LSB +: 2] != 0);
                     end
                  end else begin
                     bank_q <= i_req_addr[27:26];
                     w16_q  <= bank_w16;
                     if (open_q && i_req_seq && open_bank_q == i_req_addr[27:26]
                         && burst_q < 8'(RDM_MAX_BURST)) begin
                        st_q    <= S_CAS;
                        cnt_q   <= cas_len;                                // page
                        burst_q <= burst_q + 1'b1;
                     end else if (open_q) begin
                        open_q <= 1'b0;
                        st_q   <= S_PRE;
                        cnt_q  <= dctl_q[RDM_DCTL_PRE_BIT] ? 5'd3 : 5'd2;
                     end else begin
                        st_q    <= S_RAS;
                        burst_q <= 8'h1;
                        cnt_q   <= 5'(RDM_RCD_BASE - 1) + 5'(dctl_q[RDM_DCTL_RCD_BIT]);
                     end
                  end
               end
               // the page stays marked open until a refresh or a miss, but a rom access lifts its row strobe; a miss while it is open passes precharge
            end
            S_PRE: if (cnt_q == 0) begin
               st_q  <= S_RAS;
               burst_q <= 8'h1;
               cnt_q <= 5'(RDM_RCD_BASE - 1) + 5'(dctl_q[RDM_DCTL_RCD_BIT]);
            end
            S_RAS: if (cnt_q == 0) begin
               st_q  <= S_CAS;
               cnt_q <= cas_len;
            end
            S_ROM, S_CAS: if (cnt_q == 0) begin
               if (w16_q && !half_q && (&be_q[3:2] || st_q == S_ROM)) begin
                  rlo_q  <= mem_rdata_q;                                   // first half
                  half_q <= 1'b1;
                  cnt_q  <= (st_q == S_ROM) ? rom_len(rom_cfg_q[addr_q[24]],
                            rom_cfg_q[addr_q[24]][RDM_ROM_BURST_LSB +: 2] != 0)
                            : cas_len + 5'd1;                              // one cas high cycle
               end else begin
                  o_req_rdata <= w16_q ? {rlo_q, mem_rdata_q} : {16'h0, mem_rdata_q};
                  o_req_done  <= 1'b1;
                  if (st_q == S_CAS) begin
                     open_q      <= 1'b1;
                     open_bank_q <= bank_q;
                     st_q        <= S_TAIL;
                  end else st_q <= S_IDLE;
               end
            end
            S_TAIL: st_q <= S_IDLE;                                        // ras low, cas high
            S_REF: if (cnt_q == 0) st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   logic [28:0] ma;
   logic [3:0]  ras_n, cas_n;
   assign ma = addr_q;

   // row and column address multiplexing
   always_comb begin
      if (!w16_q) begin
         if (st_q == S_RAS || st_q == S_PRE)
            o_dram_mux_address = {ma[24], ma[22], ma[19:10]};
         else
            o_dram_mux_address = {ma[25], ma[23], ma[21:20], ma[9:2]};
      end else begin
         if (st_q == S_RAS || st_q == S_PRE)
            o_dram_mux_address = {ma[23], ma[21], ma[18:9]};
         else
            o_dram_mux_address = {ma[24], ma[22], ma[20:19], ma[8:2], half_q};
      end
   end

   // strobes, forced low by software bits
   always_comb begin
      ras_n = 4'hf;
      cas_n = 4'hf;
      if (st_q == S_REF) begin
         cas_n = 4'h0;                                                     // cas before ras
         if (cnt_q < 5'd3) ras_n = 4'h0;
      end else if ((st_q == S_RAS || st_q == S_CAS || st_q == S_TAIL) ||
                   (st_q == S_IDLE && open_q)) begin
         ras_n[bank_q] = 1'b0;
         // column strobe lifts for one cycle between the two halves
         if (st_q == S_CAS && !(half_q && cnt_q == cas_len + 5'd1))
            cas_n = w16_q ? {2'b11, ~be_q[1:0]} : ~be_q;
      end
      o_row_strobe_n    = ras_n & ~force_q[3:0];
      o_column_strobe_n = cas_n & ~force_q[7:4];
   end

   assign o_rom_cs_n          = (st_q != S_ROM);
   assign o_io_read_strobe_n  = !(st_q == S_ROM && !wr_q);
   assign o_io_write_strobe_n = !(st_q == S_ROM && wr_q && cnt_q != 0);
   assign o_mem_wdata_oen     = !(wr_q && (st_q == S_ROM || st_q == S_CAS));
   assign o_mem_wdata         = wdata_q;

   // register readback, one cycle later
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         o_reg_rdata <= '0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            RDM_ROM0_ADDR:  o_reg_rdata <= {24'h0, rom_cfg_q[0]};
            RDM_ROM1_ADDR:  o_reg_rdata <= {24'h0, rom_cfg_q[1]};
            RDM_DCTL_ADDR:  o_reg_rdata <= {24'h0, dctl_q};
            RDM_FORCE_ADDR: o_reg_rdata <= {24'h0, force_q};
            RDM_REFP_ADDR:  o_reg_rdata <= {30'h0, refp_q};
            RDM_STAT_ADDR:  o_reg_rdata <= {29'h0, ref_pend_q, open_q, st_q != S_IDLE};
            default:        o_reg_rdata <= '0;
         endcase
      end else begin
         o_reg_rdata <= '0;
      end
   end
endmodule

// >>> rdm_mem_if_chk.sv
`timescale 1ns/1ps
module rdm_mem_if_chk
   import rdm_pkg::*;
#(
   parameter int REF_CYC_MAX = RDM_REF_CYC_MAX
) (
   input wire logic        i_sys_clk,
   input wire logic        i_rstn,
   input wire logic [31:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        i_req,
   input wire logic        i_req_wr,
   input wire logic [28:0] i_req_addr,
   input wire logic        o_req_done,
   input wire logic        o_rom_cs_n,
   input wire logic        o_io_read_strobe_n,
   input wire logic        o_io_write_strobe_n,
   input wire logic [3:0]  o_row_strobe_n,
   input wire logic [3:0]  o_column_strobe_n
);
   // ----------------------------------------
   // common clock and reset
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   logic rom_req;
   // request aimed at rom space
   assign rom_req = i_req && i_req_addr[28:25] == 4'h0;

   // register port
   property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_rom_rdbk;
      i_reg_wr && i_reg_addr == RDM_ROM1_ADDR ##2 i_reg_rd && i_reg_addr == RDM_ROM1_ADDR
      |=> o_reg_rdata[7:0] == $past(i_reg_wdata[7:0], 3);
   endproperty
   a_rom_rdbk: assert property (p_rom_rdbk) else $error("rom config readback wrong");
   property p_force;
      i_reg_wr && i_reg_addr == RDM_FORCE_ADDR && i_reg_wdata[7:0] == 8'hff
      |=> o_row_strobe_n == 4'h0 && o_column_strobe_n == 4'h0;
   endproperty
   a_force: assert property (p_force) else $error("forced strobes not low");

   // access port and rom strobes
   property p_done_pulse; o_req_done |=> !o_req_done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_oe; !o_io_read_strobe_n |-> !o_rom_cs_n && i_req && !i_req_wr; endproperty
   a_oe: assert property (p_oe) else $error("rom output enable outside rom read");
   property p_we; !o_io_write_strobe_n |-> !o_rom_cs_n && i_req && i_req_wr; endproperty
   a_we: assert property (p_we) else $error("rom write enable outside rom write");
   property p_rom_time; $rose(rom_req) && !i_req_wr |-> ##[2:100] o_req_done; endproperty
   a_rom_time: assert property (p_rom_time) else $error("rom read never finished");

   // dram strobes
   property p_bank;
      &$past(o_row_strobe_n) && o_row_strobe_n != 4'hf && &o_column_strobe_n && i_req
      |-> o_row_strobe_n == ~(4'h1 << i_req_addr[27:26]);
   endproperty
   a_bank: assert property (p_bank) else $error("wrong bank row strobe");
   property p_cbr;
      $fell(o_column_strobe_n[0]) && o_row_strobe_n == 4'hf |-> ##[1:4] o_row_strobe_n == 4'h0;
   endproperty
   a_cbr: assert property (p_cbr) else $error("refresh column strobe without row strobes");
endmodule

bind rdm_mem_if rdm_mem_if_chk #(.REF_CYC_MAX(REF_CYC_MAX)) u_chk (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .i_req(i_req), .i_req_wr(i_req_wr), .i_req_addr(i_req_addr),
   .o_req_done(o_req_done), .o_rom_cs_n(o_rom_cs_n), .o_io_read_strobe_n(o_io_read_strobe_n),
   .o_io_write_strobe_n(o_io_write_strobe_n), .o_row_strobe_n(o_row_strobe_n),
   .o_column_strobe_n(o_column_strobe_n));

// >>> rdm_mem_model.sv
`timescale 1ns/1ps
module rdm_mem_model (
   input  wire logic        i_clk,
   input  wire logic [3:0]  i_row_strobe_n,
   input  wire logic [3:0]  i_column_strobe_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_edo,
   input  wire logic [11:0] i_addr,
   output logic      [15:0] o_data = 16'h0,
   output logic      [11:0] o_row = 12'h0,
   output logic      [11:0] o_col_a = 12'h0,
   output logic      [11:0] o_col_b = 12'h0,
   output logic      [15:0] o_ref_cnt = 16'h0
);
   logic [3:0] ras_q = 4'hf;
   logic [3:0] cas_q = 4'hf;
   // latch row on row strobe fall, last two columns on column fall, count refreshes
   always @(posedge i_clk) begin
      ras_q <= i_row_strobe_n;
      cas_q <= i_column_strobe_n;
      if (i_row_strobe_n == 4'h0 && ras_q != 4'h0 && !i_column_strobe_n[0]) begin
         o_ref_cnt <= o_ref_cnt + 16'h1;
      end else if (&ras_q && !(&i_row_strobe_n)) begin
         o_row <= i_addr;
      end
      if (|(cas_q & ~i_column_strobe_n) && !(&i_row_strobe_n)) begin
         o_col_a <= o_col_b;
         o_col_b <= i_addr;
      end
   end
   // data valid while selected; edo parts hold one cycle more, else the bus wanders
   always @(posedge i_clk) begin
      if (!i_oe_n) begin
         o_data <= 16'hc3a5;
      end else if (!(&i_column_strobe_n) || (i_edo && !(&cas_q))) begin
         o_data <= {o_row[3:0], i_addr};
      end else begin
         o_data <= ~o_data;
      end
   end
endmodule

// >>> test_rom_dram_memory_interface.sv
`timescale 1ns/1ps
module test_rom_dram_memory_interface;
   import rdm_pkg::*;
   localparam int REF = 256;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0, req_wr = 1'b0;
   logic seq = 1'b0, done, oen, cs_n, oe_n, we_n;
   logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, req_wd = 32'h0, req_rd, mem_wd;
   logic [28:0] req_a = 29'h0;
   logic [3:0]  be = 4'h0, ras_n, cas_n;
   logic [15:0] mdata, refs;
   logic [11:0] ma, mrow, cola, colb;
   int n_errors = 0, compares = 0, n_we = 0, n_cs = 0, n_oe = 0;

   // ----------------------------------------
   // design, memory model, clock
   // ----------------------------------------
   rdm_mem_if #(.REF_CYC_MAX(REF)) u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_req(req),
      .i_req_wr(req_wr), .i_req_seq(seq), .i_req_addr(req_a), .i_req_be(be),
      .i_req_wdata(req_wd), .o_req_done(done), .o_req_rdata(req_rd), .i_mem_rdata(mdata),
      .o_mem_wdata(mem_wd), .o_mem_wdata_oen(oen), .o_rom_cs_n(cs_n),
      .o_io_read_strobe_n(oe_n), .o_io_write_strobe_n(we_n), .o_row_strobe_n(ras_n),
      .o_column_strobe_n(cas_n), .o_dram_mux_address(ma));
   rdm_mem_model u_mem (.i_clk(clk), .i_row_strobe_n(ras_n), .i_column_strobe_n(cas_n),
      .i_oe_n(oe_n), .i_edo(1'b0), .i_addr(ma), .o_data(mdata), .o_row(mrow),
      .o_col_a(cola), .o_col_b(colb), .o_ref_cnt(refs));
   initial forever #2.5 clk = ~clk;
   // count rom strobe cycles
   always @(posedge clk) begin
      n_we <= n_we + int'(!we_n);
      n_cs <= n_cs + int'(!cs_n);
      n_oe <= n_oe + int'(!oe_n);
   end

   // ----------------------------------------
   // bus, access and compare tasks
   // ----------------------------------------
   task automatic wreg(input logic [31:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [31:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one access, held until done; returns cycles taken
   task automatic acc(input logic w, input logic [28:0] a, output int n);
      req_wr <= w;
      req_a <= a;
      be <= 4'hf;
      req_wd <= $urandom;
      req <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 300);
      if (n >= 300) n_errors++;
      req <= 1'b0;
      @(posedge clk);
   endtask
   // shortest of two tries, so a refresh in the way does not count
   task automatic lat2(input logic [28:0] a1, input logic [28:0] a2, output int n);
      int x, y;
      acc(1'b0, a1, x);
      acc(1'b0, a2, x);
      acc(1'b0, a1, y);
      acc(1'b0, a2, y);
      n = (x < y) ? x : y;
   endtask
   task automatic wait_ref(output int n);
      logic [15:0] r;
      r = refs;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (refs === r && n < 1000);
      if (n >= 1000) n_errors++;
   endtask
   function automatic logic [11:0] row_of(logic [28:0] a, logic h);
      return h ? {a[23], a[21], a[18:9]} : {a[24], a[22], a[19:10]};
   endfunction
   function automatic logic [11:0] col_of(logic [28:0] a, logic h, logic l);
      return h ? {a[24], a[22], a[20], a[19], a[8:2], l} : {a[25], a[23], a[21], a[20], a[9:2]};
   endfunction

   task automatic finish_test;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(60000 * 5);
      n_errors++;
      finish_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] d, r, ra [5];
      logic [7:0]  b, rv [5];
      logic [28:0] a;
      int n, base;
      void'($urandom(69894));
      ra = '{RDM_ROM0_ADDR, RDM_ROM1_ADDR, RDM_DCTL_ADDR, RDM_FORCE_ADDR, 32'h0320_00c0};
      rv = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00};
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rreg(ra[i], d);
         chk("reset value", {24'h0, rv[i]}, d);
      end
      for (int i = 0; i < 12; i++) begin
         b = $urandom;
         wreg(ra[i % 5], b);
         rreg(ra[i % 5], d);
         chk("register readback", (i % 5 == 2) ? {24'h0, b & 8'hef} :
             (i % 5 == 4) ? 32'h0 : {24'h0, b}, d);
         wreg(RDM_FORCE_ADDR, 8'h00);
      end
      wreg(RDM_FORCE_ADDR, 8'hff);
      #1 chk("forced strobes", 32'h0, {24'h0, ras_n, cas_n});
      @(posedge clk);
      wreg(RDM_FORCE_ADDR, 8'h00);
      for (int c = 3; c >= 0; c--) begin
         wreg(RDM_REFP_ADDR, c[7:0]);
         wait_ref(n);
         wait_ref(n);
         chk("refresh period", REF >> c, n);
      end
      // rom timing against the shortest setting
      wreg(RDM_ROM1_ADDR, 8'h20);
      wreg(RDM_ROM0_ADDR, 8'h25);
      lat2(29'h0000100, 29'h0000200, base);
      lat2(29'h1000100, 29'h1000200, n);
      chk("upper rom bank time", 32'd5, n - base);
      for (int k = 0; k < 12; k++) begin
         wreg(RDM_ROM0_ADDR, {2'b00, k[0], 2'b00, 3'(k / 2)});
         lat2(29'h0000100, 29'h0000200, n);
         chk("rom access time", (7 - k / 2) * (k[0] ? 1 : 2) - 2, n - base);
      end
      wreg(RDM_ROM0_ADDR, 8'h25);
      d = n_we + n_cs;
      acc(1'b1, 29'h0000300, n);
      chk("blocked rom write strobes", d, n_we + n_cs);
      wreg(RDM_ROM0_ADDR, 8'ha5);
      d = n_we;
      r = n_oe;
      acc(1'b1, 29'h0000300, n);
      acc(1'b0, 29'h0000300, n);
      chk("rom strobes used", 32'h3, {30'h0, n_oe != r, n_we != d});
      chk("rom read data", 32'h0000_c3a5, req_rd);
      // dram address multiplexing, random banks, widths alternating
      for (int i = 0; i < 16; i++) begin
         r = $urandom;
         a = {1'b1, r[27:2], 2'b00};
         wreg(RDM_DCTL_ADDR, {4'h0, {4{i[0]}}});
         acc(1'b0, a, n);
         chk("row address", row_of(a, i[0]), mrow);
         chk("last column", col_of(a, i[0], 1'b1), colb);
         if (i[0]) chk("first column", col_of(a, 1'b1, 1'b0), cola);
      end
      // dram timing bits each add one cycle
      rv = '{8'h00, 8'h20, 8'h40, 8'h80, 8'he0};
      for (int i = 0; i < 5; i++) begin
         wreg(RDM_DCTL_ADDR, rv[i]);
         lat2(29'h1000_0400, 29'h1004_0800, n);
         if (i == 0) base = n;
         chk("dram access time", $countones(rv[i]), n - base);
      end
      finish_test();
   end
endmodule
